// ==== pkg/ldbd_pkg.sv ====
// constants and types for the led driver bus slave and dimming core
package ldbd_pkg;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int OSC_PERIOD_NS = 40;
   localparam int STEP_CYC = (OSC_PERIOD_NS / CLK_PERIOD_NS > 0) ?
      OSC_PERIOD_NS / CLK_PERIOD_NS : 1;
   localparam logic [3:0] STEP_LAST = 4'(STEP_CYC - 1);
   localparam int PWM_STEPS = 256;
   localparam int DIM_STEP_NS = 20480;
   localparam int DIM_PER = DIM_STEP_NS / (OSC_PERIOD_NS * PWM_STEPS);
   localparam logic [1:0] DIM_LAST = 2'(DIM_PER - 1);
   localparam int BLINK_MULT = 8;
   // ----------------------------------------
   // sizes and register pointers
   // ----------------------------------------
   localparam int CHANNELS = 16;
   localparam int REG_NUM = 28;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [4:0] PTR_PRIMARY = 5'h00;
   localparam logic [4:0] PTR_SECOND = 5'h01;
   localparam logic [4:0] PTR_DUTY0 = 5'h02;
   localparam logic [4:0] PTR_GDUTY = 5'h12;
   localparam logic [4:0] PTR_GFREQ = 5'h13;
   localparam logic [4:0] PTR_MODE0 = 5'h14;
   localparam logic [4:0] PTR_SUB1 = 5'h18;
   localparam logic [4:0] PTR_GROUP = 5'h1b;
   localparam logic [4:0] PTR_LAST = 5'h1b;
   localparam int PRI_GROUP_EN = 0;
   localparam int PRI_SUB1_EN = 1;
   localparam int SEC_BLINK = 5;
   localparam int CTRL_AI = 7;
   // ----------------------------------------
   // reset values and addresses
   // ----------------------------------------
   localparam logic [7:0] RST_PRIMARY = 8'h01;
   localparam logic [7:0] RST_GDUTY = 8'hff;
   localparam logic [7:0] RST_GROUP = 8'hd0;
   localparam logic [7:0] RST_SUB1 = 8'hd2;
   localparam logic [7:0] RST_SUB2 = 8'hd4;
   localparam logic [7:0] RST_SUB3 = 8'hd8;
   localparam logic [2:0] SLAVE_BASE = 3'h6;
   localparam logic [6:0] RESET_CALL_ADDR = 7'h6b;
   localparam logic [7:0] RESET_CALL_BYTE1 = 8'ha5;
   localparam logic [7:0] RESET_CALL_BYTE2 = 8'h5a;
   localparam logic [1:0] RESET_CALL_DONE = 2'h2;
   // ----------------------------------------
   // led mode codes and types
   // ----------------------------------------
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_ON = 2'h1;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_GRP = 2'h3;
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_ADDR = 6'b000010,
      ST_WDATA = 6'b000100,
      ST_ACK = 6'b001000,
      ST_RDATA = 6'b010000,
      ST_MACK = 6'b100000
   } ldbd_state_t;
   typedef struct packed {
      logic start;
      logic stop;
      logic rise;
      logic fall;
   } ldbd_bus_ev_t;
endpackage

// ==== verilog/ldbd_core.sv ====
// bus slave, reset call and pwm dimming core of the led driver
`timescale 1ns/1ps
`default_nettype none
module ldbd_core (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // address straps
   input wire logic [3:0] addrPins,
   // bus pins
   input wire logic sclI,
   input wire logic sdaI,
   output logic sdaO,
   output logic sdaOe,
   // led sinks, high pulls the pin low
   output logic [ldbd_pkg::CHANNELS-1:0] ledSinkOe,
   // status
   output logic standby
);
   import ldbd_pkg::*;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] sclQ;
   logic [2:0] sdaQ;
   logic [3:0] pinS1Q;
   logic [3:0] pinQ;
   ldbd_bus_ev_t ev;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         sclQ <= 3'h7;
         sdaQ <= 3'h7;
         pinS1Q <= 4'h0;
         pinQ <= 4'h0;
      end else begin
         sclQ <= {sclQ[1:0], sclI};
         sdaQ <= {sdaQ[1:0], sdaI};
         pinS1Q <= addrPins;
         pinQ <= pinS1Q;
      end
   end

   always_comb begin
      ev.start = sclQ[1] & sclQ[2] & sdaQ[2] & ~sdaQ[1];
      ev.stop = sclQ[1] & sclQ[2] & ~sdaQ[2] & sdaQ[1];
      ev.rise = sclQ[1] & ~sclQ[2];
      ev.fall = ~sclQ[1] & sclQ[2];
   end

   // ----------------------------------------
   // bus state machine and registers
   // ----------------------------------------
   ldbd_state_t stateQ, stateD, afterQ, afterD;
   logic [3:0] bitQ, bitD;
   logic [7:0] shQ, shD;
   logic callQ, callD;
   logic [1:0] stageQ, stageD;
   logic firstQ, firstD;
   logic [4:0] ptrQ, ptrD;
   logic aiQ, aiD;
   logic mAckQ, mAckD;
   logic sdaOeQ, sdaOeD;
   logic swRstQ, swRstD;
   logic [7:0] regQ [REG_NUM];
   logic [7:0] regD [REG_NUM];
   logic clrAll;
   logic [6:0] addr7;
   logic isCall, hitCall, hitAddr, callOk;
   logic [7:0] rdByte;
   logic [4:0] nextPtr;

   assign clrAll = !rstn || swRstQ;

   always_comb begin
      addr7 = shQ[7:1];
      isCall = addr7 == RESET_CALL_ADDR;
      hitCall = isCall && !shQ[0];
      hitAddr = addr7 == {SLAVE_BASE, pinQ};
      if (regQ[PTR_PRIMARY][PRI_GROUP_EN] && addr7 == regQ[PTR_GROUP][7:1])
         hitAddr = 1'b1;
      for (int i = 0; i < 3; i++) begin
         if (regQ[PTR_PRIMARY][PRI_SUB1_EN+i] &&
             addr7 == regQ[int'(PTR_SUB1)+i][7:1])
            hitAddr = 1'b1;
      end
      hitAddr = hitCall || (!isCall && hitAddr);
      callOk = (stageQ == 2'h0 && shQ == RESET_CALL_BYTE1) ||
               (stageQ == 2'h1 && shQ == RESET_CALL_BYTE2);
      rdByte = (ptrQ <= PTR_LAST) ? regQ[ptrQ] : 8'h00;
      if (!aiQ)
         nextPtr = ptrQ;
      else if (ptrQ >= PTR_LAST)
         nextPtr = 5'h00;
      else
         nextPtr = ptrQ + 5'h01;
   end

   always_comb begin
      stateD = stateQ;
      afterD = afterQ;
      bitD = bitQ;
      shD = shQ;
      callD = callQ;
      stageD = stageQ;
      firstD = firstQ;
      ptrD = ptrQ;
      aiD = aiQ;
      mAckD = mAckQ;
      sdaOeD = sdaOeQ;
      swRstD = 1'b0;
      regD = regQ;
      if (ev.stop) begin
         // reset only after both bytes acked
         swRstD = callQ && stageQ == RESET_CALL_DONE;
         stateD = ST_IDLE;
         sdaOeD = 1'b0;
      end else if (ev.start) begin
         // repeated start drops any half-done reset call
         stateD = ST_ADDR;
         bitD = 4'h0;
         stageD = 2'h0;
         callD = 1'b0;
         sdaOeD = 1'b0;
      end else begin
         unique case (stateQ)
            ST_IDLE: begin
            end
            ST_ADDR, ST_WDATA: begin
               if (ev.rise && bitQ != BYTE_BITS) begin
                  shD = {shQ[6:0], sdaQ[1]};
                  bitD = bitQ + 4'h1;
               end else if (ev.fall && bitQ == BYTE_BITS) begin
                  bitD = 4'h0;
                  stateD = ST_IDLE;
                  if (stateQ == ST_ADDR) begin
                     if (hitAddr) begin
                        sdaOeD = 1'b1;
                        stateD = ST_ACK;
                        afterD = shQ[0] ? ST_RDATA : ST_WDATA;
                        callD = hitCall;
                        firstD = 1'b1;
                     end
                  end else if (callQ) begin
                     // a bad byte aborts the call
                     if (callOk) begin
                        sdaOeD = 1'b1;
                        stateD = ST_ACK;
                        afterD = ST_WDATA;
                        stageD = stageQ + 2'h1;
                     end else begin
                        stageD = 2'h0;
                     end
                  end else begin
                     sdaOeD = 1'b1;
                     stateD = ST_ACK;
                     afterD = ST_WDATA;
                     firstD = 1'b0;
                     if (firstQ) begin
                        ptrD = shQ[4:0];
                        aiD = shQ[CTRL_AI];
                     end else begin
                        if (ptrQ <= PTR_LAST)
                           regD[ptrQ] = shQ;
                        ptrD = nextPtr;
                     end
                  end
               end
            end
            ST_ACK: begin
               if (ev.fall) begin
                  stateD = afterQ;
                  sdaOeD = 1'b0;
                  if (afterQ == ST_RDATA) begin
                     shD = rdByte;
                     sdaOeD = ~rdByte[7];
                     ptrD = nextPtr;
                  end
               end
            end
            ST_RDATA: begin
               if (ev.fall) begin
                  if (bitQ == BYTE_BITS - 4'h1) begin
                     bitD = 4'h0;
                     sdaOeD = 1'b0;
                     stateD = ST_MACK;
                  end else begin
                     bitD = bitQ + 4'h1;
                     shD = {shQ[6:0], 1'b0};
                     sdaOeD = ~shQ[6];
                  end
               end
            end
            ST_MACK: begin
               if (ev.rise) begin
                  mAckD = ~sdaQ[1];
               end else if (ev.fall) begin
                  // master nack ends the read
                  stateD = ST_IDLE;
                  if (mAckQ) begin
                     shD = rdByte;
                     sdaOeD = ~rdByte[7];
                     ptrD = nextPtr;
                     stateD = ST_RDATA;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clrAll) begin
         stateQ <= ST_IDLE;
         afterQ <= ST_IDLE;
         bitQ <= 4'h0;
         shQ <= 8'h00;
         callQ <= 1'b0;
         stageQ <= 2'h0;
         firstQ <= 1'b0;
         ptrQ <= 5'h00;
         aiQ <= 1'b0;
         mAckQ <= 1'b0;
         sdaOeQ <= 1'b0;
         swRstQ <= 1'b0;
         for (int i = 0; i < REG_NUM; i++)
            regQ[i] <= 8'h00;
         regQ[PTR_PRIMARY] <= RST_PRIMARY;
         regQ[PTR_GDUTY] <= RST_GDUTY;
         regQ[PTR_SUB1] <= RST_SUB1;
         regQ[PTR_SUB1+5'h01] <= RST_SUB2;
         regQ[PTR_SUB1+5'h02] <= RST_SUB3;
         regQ[PTR_GROUP] <= RST_GROUP;
      end else begin
         stateQ <= stateD;
         afterQ <= afterD;
         bitQ <= bitD;
         shQ <= shD;
         callQ <= callD;
         stageQ <= stageD;
         firstQ <= firstD;
         ptrQ <= ptrD;
         aiQ <= aiD;
         mAckQ <= mAckD;
         sdaOeQ <= sdaOeD;
         swRstQ <= swRstD;
         regQ <= regD;
      end
   end

   // ----------------------------------------
   // pwm and group signal
   // ----------------------------------------
   logic [3:0] divQ, divD;
   logic [7:0] pwmQ, pwmD;
   logic [1:0] perQ, perD;
   logic [10:0] preQ, preD;
   logic [7:0] grpQ, grpD;
   logic [CHANNELS-1:0] ledQ, ledD;
   logic standbyQ, standbyD;
   logic stepEn, blink, grpOn, pwmOn;
   logic [10:0] preLast;
   logic [1:0] mode;

   always_comb begin
      divD = divQ;
      pwmD = pwmQ;
      perD = perQ;
      preD = preQ;
      grpD = grpQ;
      stepEn = divQ == STEP_LAST;
      divD = stepEn ? 4'h0 : divQ + 4'h1;
      // one shared group counter, blink only stretches it
      blink = regQ[PTR_SECOND][SEC_BLINK];
      // blink step scales with the period register
      preLast = blink ?
         11'(BLINK_MULT * (int'(regQ[PTR_GFREQ]) + 1) - 1) : 11'h000;
      if (stepEn) begin
         pwmD = pwmQ + 8'h01;
         if (pwmQ == 8'hff) begin
            // group step spans two pwm periods when blink is off
            perD = (perQ == DIM_LAST) ? 2'h0 : perQ + 2'h1;
            if (perQ == DIM_LAST) begin
               preD = (preQ >= preLast) ? 11'h000 : preQ + 11'h001;
               if (preQ >= preLast)
                  grpD = grpQ + 8'h01;
            end
         end
      end
      grpOn = regQ[PTR_GDUTY] > grpQ;
      standbyD = 1'b1;
      for (int i = 0; i < CHANNELS; i++) begin
         mode = regQ[int'(PTR_MODE0) + i / 4][2*(i%4) +: 2];
         pwmOn = regQ[int'(PTR_DUTY0) + i] > pwmQ;
         unique case (mode)
            MODE_OFF: ledD[i] = 1'b0;
            MODE_ON: ledD[i] = 1'b1;
            MODE_PWM: ledD[i] = pwmOn;
            MODE_GRP: ledD[i] = pwmOn & grpOn;
         endcase
         if (mode != MODE_OFF)
            standbyD = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (clrAll) begin
         divQ <= 4'h0;
         pwmQ <= 8'h00;
         perQ <= 2'h0;
         preQ <= 11'h000;
         grpQ <= 8'h00;
         ledQ <= '0;
         standbyQ <= 1'b1;
      end else begin
         divQ <= divD;
         pwmQ <= pwmD;
         perQ <= perD;
         preQ <= preD;
         grpQ <= grpD;
         ledQ <= ledD;
         standbyQ <= standbyD;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // open-drain data pin only ever drives low
   always_ff @(posedge ref_clk) begin
      sdaO <= 1'b0;
   end
   assign sdaOe = sdaOeQ;
   assign ledSinkOe = ledQ;
   assign standby = standbyQ;
endmodule // ldbd_core
`default_nettype wire

// ==== verif/ldbd_core_chk.sv ====
// port assertions for the led driver core
`timescale 1ns/1ps
`default_nettype none
module ldbd_core_chk (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // address straps and bus pins
   input wire logic [3:0] addrPins,
   input wire logic sclI,
   input wire logic sdaI,
   input wire logic sdaO,
   input wire logic sdaOe,
   // outputs
   input wire logic [ldbd_pkg::CHANNELS-1:0] ledSinkOe,
   input wire logic standby
);
   import ldbd_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   a_reset_defaults: assert property ($rose(rstn) |->
      ledSinkOe == '0 && standby && !sdaOe)
      else $error("outputs not at defaults after reset");
   a_release_dark: assert property ($rose(rstn) |=>
      (ledSinkOe == '0 && standby) [*8])
      else $error("leds lit right after reset");
   a_open_drain: assert property (sdaO == 1'b0)
      else $error("data pin output value not low");
   // the flop moved at the previous edge, so look at scl there
   a_change_scl_low: assert property ($changed(sdaOe) |->
      !$past(sclI))
      else $error("data drive changed while scl high");
   a_ack_holds: assert property ($rose(sdaOe) |-> sdaOe [*7])
      else $error("data drive too short");
   a_idle_quiet: assert property (sclI [*8] |-> !sdaOe)
      else $error("data driven while bus idle");
   a_standby_dark: assert property (standby [*2] |->
      ledSinkOe == '0)
      else $error("led lit in standby");
   a_lit_active: assert property ((|ledSinkOe) [*3] |->
      !standby)
      else $error("standby while a led is lit");
   c_ack: cover property ($rose(sdaOe));
   c_active: cover property ($fell(standby));
   c_led: cover property ($rose(ledSinkOe[0]));
endmodule // ldbd_core_chk
bind ldbd_core ldbd_core_chk chk (.ref_clk(ref_clk), .rstn(rstn),
   .addrPins(addrPins), .sclI(sclI), .sdaI(sdaI), .sdaO(sdaO),
   .sdaOe(sdaOe), .ledSinkOe(ledSinkOe), .standby(standby));
`default_nettype wire

// ==== verif/ldbd_master.sv ====
// bus master model for the led driver core
`timescale 1ns/1ps
`default_nettype none
module ldbd_master (
   // clock
   input wire logic ref_clk,
   // bus, data read back from the wired pin
   input wire logic sdaI,
   output logic sclM,
   output logic sdaM
);
   initial begin
      sclM = 1'b1;
      sdaM = 1'b1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // data moves a clock after scl falls, read mid-high
   task automatic bitx(input logic b, output logic r);
      sclM = 1'b0;
      hold(1);
      sdaM = b;
      hold(3);
      sclM = 1'b1;
      hold(2);
      r = sdaI;
      hold(2);
   endtask
   // scl low first, so a held ack never turns into a stop
   task automatic start();
      sclM = 1'b0;
      hold(4);
      sdaM = 1'b1;
      hold(4);
      sclM = 1'b1;
      hold(4);
      sdaM = 1'b0;
      hold(4);
   endtask
   task automatic stop();
      sclM = 1'b0;
      hold(1);
      sdaM = 1'b0;
      hold(3);
      sclM = 1'b1;
      hold(4);
      sdaM = 1'b1;
      hold(4);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bitx(d[i], r);
      bitx(1'b1, r);
      ack = ~r;
   endtask
   task automatic rbyte(input logic nack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bitx(1'b1, r);
         d[i] = r;
      end
      bitx(nack, r);
   endtask
endmodule // ldbd_master
`default_nettype wire

// ==== verif/test_led_driver_bus_slave_and_dimming.sv ====
// self-checking bench for the led driver core
`timescale 1ns/1ps
`default_nettype none
module test_led_driver_bus_slave_and_dimming;
   import ldbd_pkg::*;
   localparam logic [3:0] PINS = 4'h5;
   localparam logic [7:0] SLV = {SLAVE_BASE, PINS, 1'b0};
   logic ref_clk;
   logic rstn;
   logic sclM;
   logic sdaM;
   logic sdaO;
   logic sdaOe;
   logic [CHANNELS-1:0] ledSinkOe;
   logic standby;
   logic [3:0] addrPins;
   wire logic sdaPin;
   int failures;
   int samplesChecked;
   // open drain with pull-up
   assign sdaPin = sdaM & ~(sdaOe & ~sdaO);
   ldbd_core uut (.ref_clk(ref_clk), .rstn(rstn), .addrPins(addrPins),
      .sclI(sclM), .sdaI(sdaPin), .sdaO(sdaO), .sdaOe(sdaOe),
      .ledSinkOe(ledSinkOe), .standby(standby));
   ldbd_master m (.ref_clk(ref_clk), .sdaI(sdaPin), .sclM(sclM),
      .sdaM(sdaM));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      samplesChecked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d failures %0d", samplesChecked, failures);
      if (failures == 0 && samplesChecked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic addr(input logic [7:0] a, output logic ack);
      m.start();
      m.wbyte(a, ack);
   endtask
   task automatic wr(input logic [4:0] ptr, input logic [7:0] d);
      logic ack;
      addr(SLV, ack);
      m.wbyte({3'h0, ptr}, ack);
      m.wbyte(d, ack);
      m.stop();
      m.hold(4);
   endtask
   // ack of address and up to three bytes, msb first
   task automatic call(input logic [7:0] b1, input logic [7:0] b2,
      input int n, output logic [3:0] a);
      a = 4'h0;
      addr(8'hd6, a[3]);
      // master gives up at the first nack
      if (a[3] && n > 0) m.wbyte(b1, a[2]);
      if (a[2] && n > 1) m.wbyte(b2, a[1]);
      if (a[1] && n > 2) m.wbyte(8'h00, a[0]);
      m.stop();
      m.hold(4);
   endtask
   task automatic t_reset();
      rstn = 1'b0;
      m.hold(6);
      chk({sdaOe, standby, ledSinkOe}, 18'h10000);
      m.hold(6);
      rstn = 1'b1;
      m.hold(4);
      chk({sdaOe, standby, ledSinkOe}, 18'h10000);
      $display("reset test done");
   endtask
   task automatic t_slave();
      logic ack;
      logic [7:0] d;
      addr({SLAVE_BASE, PINS ^ 4'h1, 1'b0}, ack);
      m.stop();
      chk(18'(ack), 18'h0);
      // restrap the pins, the new address must answer
      addrPins = PINS ^ 4'h1;
      m.hold(4);
      addr({SLAVE_BASE, PINS ^ 4'h1, 1'b0}, ack);
      m.stop();
      chk(18'(ack), 18'h1);
      addrPins = PINS;
      m.hold(4);
      wr(PTR_MODE0, 8'h01);
      chk({sdaOe, standby, ledSinkOe}, 18'h00001);
      addr(SLV, ack);
      m.wbyte({3'h0, PTR_MODE0}, ack);
      addr(SLV | 8'h01, ack);
      chk(18'(ack), 18'h1);
      m.rbyte(1'b1, d);
      m.stop();
      chk(18'(d), 18'h1);
      $display("slave test done");
   endtask
   task automatic t_call();
      logic ack;
      logic [3:0] a;
      addr(8'hd7, ack);
      m.stop();
      chk(18'(ack), 18'h0);
      call(8'ha4, 8'h5a, 2, a);
      chk(18'(a), 18'h8);
      call(8'ha5, 8'h5b, 2, a);
      chk(18'(a), 18'hc);
      call(8'ha5, 8'h5a, 3, a);
      chk(18'(a), 18'he);
      chk({sdaOe, standby, ledSinkOe}, 18'h00001);
      call(8'ha5, 8'h5a, 2, a);
      chk(18'(a), 18'he);
      chk({sdaOe, standby, ledSinkOe}, 18'h10000);
      addr(SLV, ack);
      m.stop();
      chk(18'(ack), 18'h1);
      $display("reset call test done");
   endtask
   task automatic t_group();
      logic [7:0] subs [6] = '{8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd8, 8'hd9};
      logic ack;
      logic [7:0] d;
      addr(8'hd0, ack);
      m.stop();
      chk(18'(ack), 18'h1);
      addr(8'hd1, ack);
      chk(18'(ack), 18'h1);
      m.rbyte(1'b1, d);
      m.stop();
      chk(18'(d), 18'(RST_PRIMARY));
      foreach (subs[k]) begin
         addr(subs[k], ack);
         m.stop();
         chk(18'(ack), 18'h0);
      end
      $display("group test done");
   endtask
   task automatic t_pwm();
      logic [7:0] duty [3] = '{8'h01, 8'h40, 8'hff};
      int i;
      int n;
      wr(PTR_MODE0, 8'h02);
      foreach (duty[k]) begin
         wr(PTR_DUTY0, duty[k]);
         // let a period with the old duty run out
         m.hold(PWM_STEPS);
         for (i = 0; i < 300 && ledSinkOe[0] !== 1'b1; i++) m.hold(1);
         if (i == 300) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, ledSinkOe[0], 1'b1);
            failures++;
            complete_run();
         end
         n = 0;
         repeat (PWM_STEPS) begin
            m.hold(1);
            n += int'(ledSinkOe[0] === 1'b1);
         end
         chk(18'(n), 18'(duty[k]));
         chk(18'(standby), 18'h0);
      end
      $display("pwm test done");
   endtask
   // lit cycles of channel 0 over one pwm period
   task automatic lit(output int n);
      n = 0;
      repeat (PWM_STEPS) begin
         m.hold(1);
         n += int'(ledSinkOe[0] === 1'b1);
      end
   endtask
   task automatic t_dim();
      int n;
      wr(PTR_MODE0, {6'h00, MODE_GRP});
      wr(PTR_DUTY0, 8'h80);
      lit(n);
      chk(18'(n), 18'h80);
      wr(PTR_GDUTY, 8'h00);
      lit(n);
      chk(18'(n), 18'h0);
      wr(PTR_MODE0, {6'h00, MODE_OFF});
      chk({sdaOe, standby, ledSinkOe}, 18'h10000);
      $display("dimming test done");
   endtask
   task automatic t_hold();
      logic ack;
      wr(PTR_MODE0, 8'h01);
      addr(SLV, ack);
      rstn = 1'b0;
      m.hold(2);
      chk({sdaOe, standby, ledSinkOe}, 18'h10000);
      rstn = 1'b1;
      m.stop();
      chk({sdaOe, standby, ledSinkOe}, 18'h10000);
      $display("mid-run reset test done");
   endtask
   initial begin
      failures = 0;
      samplesChecked = 0;
      addrPins = PINS;
      t_reset();
      t_slave();
      t_call();
      t_group();
      t_pwm();
      t_dim();
      t_hold();
      complete_run();
   end
endmodule // test_led_driver_bus_slave_and_dimming
`default_nettype wire
